// File: cgen_pkg.sv
// Shared constants and types for the CPU clock generator.
package cgen_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] OFS_SYS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  // Field positions.
  localparam int OSC_WDT_DIS_POS = 4;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BACKUP_POS = 3;
  localparam int ST_OSC_IRQ_POS = 4;
  localparam int ST_UNLOCK_IRQ_POS = 5;
  localparam int ST_PLL_ON_POS = 6;
  // Reset values.
  localparam logic OSC_WDT_DIS_RESET = 1'b0;
  localparam logic [31:0] READDATA_RESET = 32'h0000_0000;
  // Strap codes.
  localparam logic [2:0] STRAP_X4 = 3'h7;
  localparam logic [2:0] STRAP_X3 = 3'h6;
  localparam logic [2:0] STRAP_X8 = 3'h5;
  localparam logic [2:0] STRAP_X5 = 3'h4;
  localparam logic [2:0] STRAP_DIRECT = 3'h3;
  localparam logic [2:0] STRAP_X10 = 3'h2;
  localparam logic [2:0] STRAP_PRESC = 3'h1;
  localparam logic [2:0] STRAP_X16 = 3'h0;
  localparam logic [2:0] STRAP_DEFAULT = STRAP_X4;
  // Timing counts in reference clock cycles, except WDT_OVF_LAST in free-running PLL ticks.
  localparam logic [3:0] WDT_OVF_LAST = 4'hf;
  localparam int FREE_HALF_DIV = 4;
  localparam int LOCK_TIMEOUT = 1024;
  localparam int PERIOD_W = 16;
  localparam logic [15:0] PERIOD_RESET = 16'h0028;

  typedef enum logic [2:0] {ST_STRAP, ST_DIRECT, ST_PRESC, ST_PLL, ST_BACKUP} src_state_t;

  // Multiplication factor of a PLL strap code.
  function automatic logic [4:0] pll_factor(input logic [2:0] code);
    logic [4:0] f;
    f = 5'h04;
    unique case (code)
      STRAP_X3: f = 5'h03;
      STRAP_X8: f = 5'h08;
      STRAP_X5: f = 5'h05;
      STRAP_X10: f = 5'h0a;
      STRAP_X16: f = 5'h10;
      STRAP_X4, STRAP_DIRECT, STRAP_PRESC: f = 5'h04;
    endcase
    return f;
  endfunction
endpackage

// File: clk_sync.sv
// Two-stage synchroniser for asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module clk_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // No reset, so the straps are sampled while the reset is still held.
  always_ff @(posedge i_ref_clk) begin
    stage1 <= i_async;
    o_sync <= stage1;
  end
endmodule
`default_nettype wire

// File: cpu_clock_generator.sv
// CPU clock generator with strap-selected mode and oscillator watchdog.
// Operation
// - Strap pins sampled during reset pick the clock mode until next reset.
// - Codes 111 x4 default, 110 x3, 101 x8, 100 x5, 010 x10, 011 x1, 001 /2.
// - Code 001 divides the input clock by two for the CPU clock.
// - Prescaler high and low phases each last one input period.
// - Code 011 bypasses amplifier, CPU clock follows input; PLL stays on only for the watchdog.
// - Direct drive phases follow input duty; two phases equal one period.
// - Other codes run the PLL giving input frequency times factor.
// - PLL resynchronises every F-th input transition, gradually, no frequency step.
// - Both CPU clock edges are events; interval between edges is basic unit.
// - Watchdog on after reset; system config bit 4 disables it.
// - Watchdog works only in direct drive and prescaler modes.
// - Free-running PLL clock increments counter; input transitions clear it.
// - Sixteen PLL cycles without input transition means clock failure.
// - On failure switch CPU clock to backup and raise watchdog interrupt.
// - Backup clock kept until reset even if input clock returns.
// - Watchdog disabled in direct or prescaler mode: input clock, PLL off.
// - PLL unlock raises interrupt, disconnects reference, PLL free-runs as backup.
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_generator #(
  parameter int FREE_DIV = cgen_pkg::FREE_HALF_DIV,
  parameter int LOCK_LIMIT = cgen_pkg::LOCK_TIMEOUT
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_clock_input_pin,
  input wire logic [2:0] i_clock_mode_strap_pins,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_cpu_clk,
  output logic o_half_clock_interval,
  output logic o_pll_enable,
  output logic o_osc_amp_bypass,
  output logic o_backup_clock_active,
  output logic o_osc_watchdog_irq,
  output logic o_pll_unlock_irq
);
  localparam int PW = cgen_pkg::PERIOD_W;
  localparam logic [PW-1:0] PER_MAX = {PW{1'b1}};
  localparam logic [PW-1:0] LOCK_CNT = PW'(LOCK_LIMIT);
  localparam logic [7:0] FREE_LAST = 8'(FREE_DIV - 1);

  logic in_s;
  logic in_d;
  logic in_rise;
  logic in_edge;
  logic [2:0] strap_s;
  logic [2:0] clock_mode_strap_bits;
  cgen_pkg::src_state_t src;
  logic osc_watchdog_disable_bit;
  logic wdt_on;
  logic [3:0] wdt_cnt;
  logic osc_fail;
  logic pll_unlock;
  logic switch_req;
  logic [7:0] free_div;
  logic free_tick;
  logic [PW-1:0] per_cnt;
  logic [PW-1:0] est;
  logic est_valid;
  logic [4:0] trans_cnt;
  logic [4:0] factor;
  logic [PW-1:0] step;
  logic [PW-1:0] acc;
  logic [PW:0] acc_sum;
  logic nco_tick;
  logic next_cpu;
  logic bus_done;
  logic wr_config;
  logic wr_status;
  logic [31:0] status_word;

  clk_sync #(.WIDTH(1)) u_in_sync (
    .i_ref_clk(i_ref_clk),
    .i_async(i_clock_input_pin),
    .o_sync(in_s)
  );

  clk_sync #(.WIDTH(3)) u_strap_sync (
    .i_ref_clk(i_ref_clk),
    .i_async(i_clock_mode_strap_pins),
    .o_sync(strap_s)
  );

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_d <= 1'b0;
    end else begin
      in_d <= in_s;
    end
  end

  assign in_rise = in_s & ~in_d;
  assign in_edge = in_s ^ in_d;
  assign factor = cgen_pkg::pll_factor(clock_mode_strap_bits);
  assign step = PW'({factor, 1'b0});
  assign switch_req = osc_fail | pll_unlock;

  // Mode is taken from the synchronised straps once, in the first cycle after release.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_mode_strap_bits <= cgen_pkg::STRAP_DEFAULT;
    end else if (src == cgen_pkg::ST_STRAP) begin
      clock_mode_strap_bits <= strap_s;
    end
  end

  // Source selection; backup is entered only while the CPU clock is low.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src <= cgen_pkg::ST_STRAP;
    end else begin
      unique case (src)
        cgen_pkg::ST_STRAP: begin
          if (strap_s == cgen_pkg::STRAP_DIRECT) begin
            src <= cgen_pkg::ST_DIRECT;
          end else if (strap_s == cgen_pkg::STRAP_PRESC) begin
            src <= cgen_pkg::ST_PRESC;
          end else begin
            src <= cgen_pkg::ST_PLL;
          end
        end
        cgen_pkg::ST_DIRECT, cgen_pkg::ST_PRESC, cgen_pkg::ST_PLL: begin
          if (switch_req && !o_cpu_clk) begin
            src <= cgen_pkg::ST_BACKUP;
          end
        end
        cgen_pkg::ST_BACKUP: src <= cgen_pkg::ST_BACKUP;
      endcase
    end
  end

  // Free-running PLL clock, modelled as an enable pulse while the PLL is powered.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      free_div <= 8'h00;
      free_tick <= 1'b0;
    end else if (!o_pll_enable) begin
      free_div <= 8'h00;
      free_tick <= 1'b0;
    end else begin
      free_tick <= (free_div == FREE_LAST);
      free_div <= (free_div == FREE_LAST) ? 8'h00 : free_div + 8'h01;
    end
  end

  assign wdt_on = !osc_watchdog_disable_bit && !osc_fail
    && (src == cgen_pkg::ST_DIRECT || src == cgen_pkg::ST_PRESC);

  // Oscillator watchdog counter and sticky failure.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdt_cnt <= 4'h0;
      osc_fail <= 1'b0;
    end else if (!wdt_on) begin
      wdt_cnt <= 4'h0;
    end else if (in_edge) begin
      wdt_cnt <= 4'h0;
    end else if (free_tick) begin
      if (wdt_cnt == cgen_pkg::WDT_OVF_LAST) begin
        osc_fail <= 1'b1;
      end else begin
        wdt_cnt <= wdt_cnt + 4'h1;
      end
    end
  end

  // Input period measurement and loss-of-lock detection in PLL mode.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      per_cnt <= '0;
      pll_unlock <= 1'b0;
    end else begin
      if (in_rise) begin
        per_cnt <= PW'(1);
      end else if (per_cnt != PER_MAX) begin
        per_cnt <= per_cnt + PW'(1);
      end
      if (src == cgen_pkg::ST_PLL && per_cnt >= LOCK_CNT) begin
        pll_unlock <= 1'b1;
      end
    end
  end

  // Period estimate: first period loads directly, later ones nudge by one every F-th transition.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      est <= cgen_pkg::PERIOD_RESET;
      est_valid <= 1'b0;
      trans_cnt <= 5'h00;
    end else if (src == cgen_pkg::ST_PLL && !pll_unlock && in_edge) begin
      trans_cnt <= (trans_cnt + 5'h01 >= factor) ? 5'h00 : trans_cnt + 5'h01;
      if (in_rise && !est_valid && per_cnt != PER_MAX && per_cnt >= step) begin
        est <= per_cnt;
        est_valid <= 1'b1;
      end else if (trans_cnt + 5'h01 >= factor && est_valid) begin
        if (per_cnt > est && est != PER_MAX) begin
          est <= est + PW'(1);
        end else if (per_cnt < est && in_rise && est > step) begin
          est <= est - PW'(1);
        end
      end
    end
  end

  // Accumulator yields 2F CPU clock edges per estimated input period.
  assign acc_sum = {1'b0, acc} + {1'b0, step};
  assign nco_tick = (acc_sum >= {1'b0, est});

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc <= '0;
    end else if (src != cgen_pkg::ST_PLL) begin
      acc <= '0;
    end else if (nco_tick) begin
      acc <= PW'(acc_sum - {1'b0, est});
    end else begin
      acc <= acc_sum[PW-1:0];
    end
  end

  // CPU clock: a pending switch may only stretch a high phase until a backup tick.
  always_comb begin
    next_cpu = o_cpu_clk;
    unique case (src)
      cgen_pkg::ST_STRAP: next_cpu = 1'b0;
      cgen_pkg::ST_DIRECT: begin
        if (switch_req) begin
          next_cpu = o_cpu_clk && !free_tick;
        end else begin
          next_cpu = in_s;
        end
      end
      cgen_pkg::ST_PRESC: begin
        if (switch_req) begin
          next_cpu = o_cpu_clk && !free_tick;
        end else if (in_rise) begin
          next_cpu = !o_cpu_clk;
        end
      end
      cgen_pkg::ST_PLL: begin
        if (switch_req) begin
          next_cpu = o_cpu_clk && !free_tick;
        end else if (nco_tick) begin
          next_cpu = !o_cpu_clk;
        end
      end
      cgen_pkg::ST_BACKUP: begin
        if (free_tick) begin
          next_cpu = !o_cpu_clk;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpu_clk <= 1'b0;
      o_half_clock_interval <= 1'b0;
    end else begin
      o_cpu_clk <= next_cpu;
      o_half_clock_interval <= (next_cpu != o_cpu_clk);
    end
  end

  // Analog control outputs.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pll_enable <= 1'b0;
      o_osc_amp_bypass <= 1'b0;
      o_backup_clock_active <= 1'b0;
    end else begin
      o_pll_enable <= (src == cgen_pkg::ST_PLL) || (src == cgen_pkg::ST_BACKUP)
        || wdt_on || switch_req;
      o_osc_amp_bypass <= (src == cgen_pkg::ST_DIRECT);
      o_backup_clock_active <= (src == cgen_pkg::ST_BACKUP);
    end
  end

  // Avalon-MM slave: one wait cycle on every access.
  assign bus_done = (i_read || i_write) && !o_waitrequest;
  assign wr_config = i_write && !o_waitrequest && i_byteenable[0] && i_address == cgen_pkg::OFS_SYS_CONFIG;
  assign wr_status = i_write && !o_waitrequest && i_byteenable[0] && i_address == cgen_pkg::OFS_STATUS;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[cgen_pkg::ST_MODE_LSB +: 3] = clock_mode_strap_bits;
    status_word[cgen_pkg::ST_BACKUP_POS] = o_backup_clock_active;
    status_word[cgen_pkg::ST_OSC_IRQ_POS] = o_osc_watchdog_irq;
    status_word[cgen_pkg::ST_UNLOCK_IRQ_POS] = o_pll_unlock_irq;
    status_word[cgen_pkg::ST_PLL_ON_POS] = o_pll_enable;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_waitrequest <= 1'b1;
      o_readdata <= cgen_pkg::READDATA_RESET;
    end else if ((i_read || i_write) && o_waitrequest) begin
      o_waitrequest <= 1'b0;
      if (i_read && i_address == cgen_pkg::OFS_SYS_CONFIG) begin
        o_readdata <= 32'(osc_watchdog_disable_bit) << cgen_pkg::OSC_WDT_DIS_POS;
      end else if (i_read && i_address == cgen_pkg::OFS_STATUS) begin
        o_readdata <= status_word;
      end else begin
        o_readdata <= 32'h0000_0000;
      end
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_watchdog_disable_bit <= cgen_pkg::OSC_WDT_DIS_RESET;
    end else if (wr_config) begin
      osc_watchdog_disable_bit <= i_writedata[cgen_pkg::OSC_WDT_DIS_POS];
    end
  end

  // Interrupt flags: the hardware set wins over a write-one clear.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_osc_watchdog_irq <= 1'b0;
      o_pll_unlock_irq <= 1'b0;
    end else begin
      if (wdt_on && !in_edge && free_tick && wdt_cnt == cgen_pkg::WDT_OVF_LAST) begin
        o_osc_watchdog_irq <= 1'b1;
      end else if (wr_status && i_writedata[cgen_pkg::ST_OSC_IRQ_POS]) begin
        o_osc_watchdog_irq <= 1'b0;
      end
      if (src == cgen_pkg::ST_PLL && per_cnt >= LOCK_CNT && !pll_unlock) begin
        o_pll_unlock_irq <= 1'b1;
      end else if (wr_status && i_writedata[cgen_pkg::ST_UNLOCK_IRQ_POS]) begin
        o_pll_unlock_irq <= 1'b0;
      end
    end
  end

  AST_MODE_HELD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (src != cgen_pkg::ST_STRAP) |=> $stable(clock_mode_strap_bits))
    else $error("Clock mode changed after capture.");

  AST_PRESC_TOGGLE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (src == cgen_pkg::ST_PRESC && !switch_req && in_rise) |=> (o_cpu_clk != $past(o_cpu_clk)))
    else $error("Prescaler did not toggle on input rise.");

  AST_DIRECT_FOLLOW: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (src == cgen_pkg::ST_DIRECT && !switch_req) |=> (o_cpu_clk == $past(in_s)))
    else $error("Direct drive clock does not follow input.");

  AST_WDT_OVERFLOW: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wdt_on && wdt_cnt == cgen_pkg::WDT_OVF_LAST && free_tick && !in_edge) |=> (osc_fail && o_osc_watchdog_irq))
    else $error("Watchdog overflow did not flag failure.");

  AST_WDT_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wdt_on && in_edge) |=> (wdt_cnt == 4'h0))
    else $error("Input transition did not clear watchdog counter.");

  AST_BACKUP_STICKY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (src == cgen_pkg::ST_BACKUP) |=> (src == cgen_pkg::ST_BACKUP) [*8])
    else $error("Backup clock source was left.");

  AST_PLL_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (osc_watchdog_disable_bit && !switch_req
      && (src == cgen_pkg::ST_DIRECT || src == cgen_pkg::ST_PRESC)) |=> !o_pll_enable)
    else $error("PLL powered while watchdog disabled.");

  AST_SWITCH_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (src != cgen_pkg::ST_BACKUP ##1 src == cgen_pkg::ST_BACKUP) |-> !$past(o_cpu_clk))
    else $error("Source switched while CPU clock high.");

  AST_FAIL_SWITCH: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ($rose(osc_fail) && !o_cpu_clk) |=> (src == cgen_pkg::ST_BACKUP))
    else $error("Failure did not switch to backup clock.");

  AST_BUS_ONE_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest)
    else $error("Bus answer not one cycle after request.");
endmodule
`default_nettype wire

// File: cpu_clock_generator_bench.sv
// Self-checking testbench for the CPU clock generator.
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_generator_bench;
  logic ref_clk, resetn, osc_run, ext_clk, read, write;
  logic [2:0] straps;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic waitrequest, cpu_clk, half_interval, pll_enable, amp_bypass, backup_active, osc_irq, unlock_irq;
  int errors, total_checks, n;

  cpu_clock_generator #(.FREE_DIV(4), .LOCK_LIMIT(64)) u_cpu_clock_generator (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_clock_input_pin(ext_clk),
    .i_clock_mode_strap_pins(straps), .i_address(address), .i_read(read), .i_write(write),
    .i_writedata(writedata), .i_byteenable(byteenable), .o_readdata(readdata),
    .o_waitrequest(waitrequest), .o_cpu_clk(cpu_clk), .o_half_clock_interval(half_interval),
    .o_pll_enable(pll_enable), .o_osc_amp_bypass(amp_bypass), .o_backup_clock_active(backup_active),
    .o_osc_watchdog_irq(osc_irq), .o_pll_unlock_irq(unlock_irq)
  );

  // Input period is 200 ns, eight reference cycles.
  ext_clock_source #(.HALF_NS(100)) u_ext_clock_source (.i_run(osc_run), .o_clk(ext_clk));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    forever begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) begin
        break;
      end
      k++;
      if (k > 20) begin
        $display("Bus answer missing at %0t", $time);
        errors++;
        conclude();
      end
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    bus_access(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  function automatic logic [31:0] st(input logic [2:0] m, input logic b, input logic q, input logic p);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[2:0] = m;
    v[cgen_pkg::ST_BACKUP_POS] = b;
    v[cgen_pkg::ST_OSC_IRQ_POS] = q;
    v[cgen_pkg::ST_PLL_ON_POS] = p;
    return v;
  endfunction

  task automatic do_reset(input logic [2:0] code);
    @(posedge ref_clk);
    resetn <= 1'b0;
    straps <= code;
    osc_run <= 1'b1;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Cycles between two pulses of the half clock interval strobe.
  task automatic measure_interval(input int exp);
    logic lvl;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (half_interval !== 1'b1 && n < 100);
    lvl = cpu_clk;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (half_interval !== 1'b1 && n < 100);
    check(n, exp);
    check(cpu_clk, !lvl);
  endtask

  task automatic count_pulses(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(posedge ref_clk);
      if (half_interval === 1'b1) begin
        n++;
      end
    end
  endtask

  task automatic wait_cycles_for_backup();
    n = 0;
    while (backup_active !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(backup_active, 1'b1);
  endtask

  task automatic test_pll_modes();
    logic [2:0] codes [4] = '{3'h6, 3'h5, 3'h4, 3'h2};
    foreach (codes[i]) begin
      do_reset(codes[i]);
      reg_check(cgen_pkg::OFS_STATUS, st(codes[i], 1'b0, 1'b0, 1'b1));
      check(amp_bypass, 1'b0);
    end
    do_reset(3'h6);
    repeat (300) @(posedge ref_clk);
    count_pulses(400);
    check_range(n, 284, 316);
    do_reset(3'h7);
    reg_check(cgen_pkg::OFS_SYS_CONFIG, 32'h0000_0000);
    repeat (300) @(posedge ref_clk);
    count_pulses(400);
    check_range(n, 380, 420);
    straps <= 3'h1;
    repeat (10) @(posedge ref_clk);
    reg_check(cgen_pkg::OFS_STATUS, st(3'h7, 1'b0, 1'b0, 1'b1));
    reg_check(4'h8, 32'h0000_0000);
    bus_access(1'b1, 4'h8, 32'hffff_ffff);
    byteenable <= 4'he;
    bus_access(1'b1, cgen_pkg::OFS_SYS_CONFIG, 32'hffff_ffff);
    byteenable <= 4'hf;
    reg_check(cgen_pkg::OFS_SYS_CONFIG, 32'h0000_0000);
    osc_run <= 1'b0;
    n = 0;
    while (unlock_irq !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(unlock_irq, 1'b1);
    check(osc_irq, 1'b0);
    wait_cycles_for_backup();
    $display("test pll modes done");
  endtask

  task automatic test_direct();
    do_reset(3'h3);
    reg_check(cgen_pkg::OFS_STATUS, st(3'h3, 1'b0, 1'b0, 1'b1));
    check(amp_bypass, 1'b1);
    measure_interval(4);
    @(posedge ref_clk);
    osc_run <= 1'b0;
    n = 0;
    while (osc_irq !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check_range(n, 56, 80);
    wait_cycles_for_backup();
    measure_interval(4);
    osc_run <= 1'b1;
    repeat (100) @(posedge ref_clk);
    check(backup_active, 1'b1);
    reg_check(cgen_pkg::OFS_STATUS, st(3'h3, 1'b1, 1'b1, 1'b1));
    bus_access(1'b1, cgen_pkg::OFS_STATUS, 32'h0000_0010);
    reg_check(cgen_pkg::OFS_STATUS, st(3'h3, 1'b1, 1'b0, 1'b1));
    do_reset(3'h3);
    check(backup_active, 1'b0);
    $display("test direct done");
  endtask

  task automatic test_prescaler();
    do_reset(3'h1);
    bus_access(1'b1, cgen_pkg::OFS_SYS_CONFIG, 32'h0000_0010);
    reg_check(cgen_pkg::OFS_SYS_CONFIG, 32'h0000_0010);
    reg_check(cgen_pkg::OFS_STATUS, st(3'h1, 1'b0, 1'b0, 1'b0));
    check(pll_enable, 1'b0);
    measure_interval(8);
    osc_run <= 1'b0;
    repeat (200) @(posedge ref_clk);
    check(backup_active, 1'b0);
    check(osc_irq, 1'b0);
    osc_run <= 1'b1;
    bus_access(1'b1, cgen_pkg::OFS_SYS_CONFIG, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    check(pll_enable, 1'b1);
    measure_interval(8);
    osc_run <= 1'b0;
    wait_cycles_for_backup();
    check(osc_irq, 1'b1);
    $display("test prescaler done");
  endtask

  initial begin
    resetn = 1'b0;
    osc_run = 1'b1;
    straps = 3'h7;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    errors = 0;
    total_checks = 0;
    test_pll_modes();
    test_direct();
    test_prescaler();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    $display("Run limit reached at %0t", $time);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// File: ext_clock_source.sv
// Behavioural external oscillator that drives the clock input pin.
`timescale 1ns/100ps
`default_nettype none
module ext_clock_source #(
  parameter int HALF_NS = 100
) (
  input wire logic i_run,
  output logic o_clk
);
  // A stopped oscillator holds its last level, the way a failed crystal leaves the pin.
  initial begin
    o_clk = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      if (i_run) begin
        o_clk = ~o_clk;
      end
    end
  end
endmodule
`default_nettype wire
